// ---- src/eps_defs.vh ----
// constants for the encoder pulse output and scaling block
`ifndef EPS_DEFS_VH
`define EPS_DEFS_VH
// register indices, byte address is four times the index
`define EPS_IDX_TRQ_FS 10'h01A
`define EPS_IDX_PULSE 10'h01B
`define EPS_IDX_TRQ_LIM 10'h01C
`define EPS_IDX_SPD_OFS 10'h01D
`define EPS_IDX_TRQ_OFS 10'h01E
`define EPS_IDX_MON1_OFS 10'h01F
`define EPS_IDX_MON2_OFS 10'h020
`define EPS_IDX_MODE 10'h036
`define EPS_IDX_CTRL 10'h040
`define EPS_IDX_STAT 10'h041
// reset values
`define EPS_RST_TRQ_FS 16'h0064
`define EPS_RST_PULSE 16'h0FA0
`define EPS_RST_TRQ_LIM 16'h0064
`define EPS_RST_OFS 16'h0000
`define EPS_RST_MODE 16'h0000
// setting ranges
`define EPS_TRQ_FS_MAX 16'h03E8
`define EPS_TRQ_LIM_MAX 16'h0064
`define EPS_PULSE_MIN 16'h0001
`define EPS_OFS_MAX 17'sh003E7
`define EPS_OFS_MIN -17'sh003E7
// output mode field and its codes
`define EPS_MODE_HI 15
`define EPS_MODE_LO 12
`define EPS_MODE_DIV 4'h1
// control register fields
`define EPS_CTRL_CAL 0
// control modes of the drive
`define EPS_CM_POS 2'h0
`define EPS_CM_SPD 2'h1
`define EPS_CM_TRQ 2'h2
// encoder counts per motor revolution
`define EPS_ENC_RES 40'sh0000020000
// torque: mV * setting / 800 gives 0.1 % of max torque (8000 mV full scale)
`define EPS_TRQ_DIV 32'sh00000320
// analog limit: mV / 8 gives 0.1 % (8000 mV is 100 %)
`define EPS_ALIM_SHIFT 3
// internal limit percent to 0.1 % units
`define EPS_LIM_SCALE 17'sh0000A
// auto offset settle time in cycles
`define EPS_CAL_WAIT 16'h0400
`endif

// ---- src/eps_top.v ----
// encoder pulse emulation, torque scaling and analog offsets with an apb register file
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "eps_defs.vh"

// Operation
// - setting counts quadrature edges, so a/b pulse count is a quarter of it
// - pulse designation mode: setting is output count per motor revolution
// - division mode: encoder resolution divided by setting per revolution
// - pulse setting range 1 to 65535, reset value 4000
// - internal torque limit 0 to 100 percent, reset 100, zero gives zero torque
// - torque mode: 8 V full scale gives max torque times setting over 100
// - signed speed command or limit offset, -999 to 999, auto calibration writes it
// - signed torque command or limit offset, reset zero, magnitude to 999
// - two monitor channel offsets, -999 to 999, reset zero
module eps_top (
    // clock and reset
    input wire core_clk_in,
    input wire nrst_in,
    // apb slave
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [11:0] paddr_in,
    input wire [31:0] pwdata_in,
    output reg [31:0] prdata_out,
    output reg pready_out,
    output reg pslverr_out,
    // motor side, same clock
    input wire [16:0] motor_pos_in,
    input wire [1:0] control_mode_in,
    // analog channels in mV, signed, same clock
    input wire [15:0] torque_command_input_in,
    input wire [15:0] speed_command_input_in,
    input wire [15:0] speed_limit_input_in,
    input wire [15:0] torque_limit_input_in,
    input wire [15:0] monitor_ch1_in,
    input wire [15:0] monitor_ch2_in,
    // encoder emulation
    output reg enc_a_out,
    output reg enc_b_out,
    // scaled results
    output reg [15:0] torque_ref_out,
    output reg [15:0] speed_ref_mv_out,
    output reg [15:0] monitor_ch1_mv_out,
    output reg [15:0] monitor_ch2_mv_out
);

    localparam CAL_IDLE = 2'h0;
    localparam CAL_WAIT = 2'h1;
    localparam CAL_TAKE = 2'h2;

    // clamp a signed value into the offset range
    function [15:0] clamp_ofs;
        input signed [16:0] v;
        reg signed [16:0] c;
        begin
            if (v > `EPS_OFS_MAX) begin
                c = `EPS_OFS_MAX;
            end else if (v < `EPS_OFS_MIN) begin
                c = `EPS_OFS_MIN;
            end else begin
                c = v;
            end
            clamp_ofs = c[15:0];
        end
    endfunction

    // add a stored offset to an input sample, 17 bit result
    function signed [16:0] add_ofs;
        input [15:0] a;
        input [15:0] b;
        begin
            add_ofs = $signed({a[15], a}) + $signed({b[15], b});
        end
    endfunction

    // settings
    reg [15:0] torque_cmd_full_scale_r;
    reg [15:0] encoder_out_pulse_setting_r;
    reg [15:0] internal_torque_limit_one_r;
    reg [15:0] speed_cmd_offset_r;
    reg [15:0] torque_cmd_offset_r;
    reg [15:0] monitor_ch1_offset_r;
    reg [15:0] monitor_ch2_offset_r;
    reg [15:0] out_mode_r;
    // auto offset state
    reg [1:0] cal_state_r;
    reg [15:0] cal_cnt_r;
    // encoder emulation state
    reg [16:0] pos_prev_r;
    reg signed [39:0] acc_r;
    reg [1:0] quad_r;
    reg [15:0] edge_cnt_r;

    wire [9:0] idx = paddr_in[11:2];
    wire aligned = (paddr_in[1:0] == 2'h0);
    wire setup_ph = psel_in & ~penable_in;
    wire wr_now = psel_in & penable_in & pready_out & pwrite_in;
    wire [16:0] wr_s = {pwdata_in[15], pwdata_in[15:0]};
    wire cal_go = wr_now & aligned & (idx == `EPS_IDX_CTRL) & pwdata_in[`EPS_CTRL_CAL];
    wire torque_mode = (control_mode_in == `EPS_CM_TRQ);

    // index decode for the error path; the read mux decodes on its own
    function known_idx;
        input [9:0] i;
        begin
            case (i)
                `EPS_IDX_TRQ_FS, `EPS_IDX_PULSE, `EPS_IDX_TRQ_LIM, `EPS_IDX_SPD_OFS, `EPS_IDX_TRQ_OFS,
                `EPS_IDX_MON1_OFS, `EPS_IDX_MON2_OFS, `EPS_IDX_MODE, `EPS_IDX_CTRL, `EPS_IDX_STAT: begin
                    known_idx = 1'b1;
                end
                default: begin
                    known_idx = 1'b0;
                end
            endcase
        end
    endfunction

    // read mux, narrow registers sit in the low bits
    reg [31:0] rd_nxt;
    always @* begin
        case (idx)
            `EPS_IDX_TRQ_FS: rd_nxt = {16'h0000, torque_cmd_full_scale_r};
            `EPS_IDX_PULSE: rd_nxt = {16'h0000, encoder_out_pulse_setting_r};
            `EPS_IDX_TRQ_LIM: rd_nxt = {16'h0000, internal_torque_limit_one_r};
            `EPS_IDX_SPD_OFS: rd_nxt = {{16{speed_cmd_offset_r[15]}}, speed_cmd_offset_r};
            `EPS_IDX_TRQ_OFS: rd_nxt = {{16{torque_cmd_offset_r[15]}}, torque_cmd_offset_r};
            `EPS_IDX_MON1_OFS: rd_nxt = {{16{monitor_ch1_offset_r[15]}}, monitor_ch1_offset_r};
            `EPS_IDX_MON2_OFS: rd_nxt = {{16{monitor_ch2_offset_r[15]}}, monitor_ch2_offset_r};
            `EPS_IDX_MODE: rd_nxt = {16'h0000, out_mode_r};
            `EPS_IDX_CTRL: rd_nxt = {31'h00000000, cal_state_r != CAL_IDLE};
            `EPS_IDX_STAT: rd_nxt = {13'h0000, quad_r, cal_state_r != CAL_IDLE, edge_cnt_r};
            default: rd_nxt = 32'h00000000;
        endcase
    end

    // apb: ready in the cycle after setup, so every transfer takes two cycles
    always @(posedge core_clk_in) begin
        if (!nrst_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h00000000;
        end else begin
            pready_out <= setup_ph & ~pready_out;
            pslverr_out <= setup_ph & ~(aligned & known_idx(idx));
            if (setup_ph & ~pwrite_in & aligned) begin
                prdata_out <= rd_nxt;
            end else if (setup_ph) begin
                prdata_out <= 32'h00000000;
            end
        end
    end

    // setting writes, out of range values are clamped rather than refused
    always @(posedge core_clk_in) begin
        if (!nrst_in) begin
            torque_cmd_full_scale_r <= `EPS_RST_TRQ_FS;
            encoder_out_pulse_setting_r <= `EPS_RST_PULSE;
            internal_torque_limit_one_r <= `EPS_RST_TRQ_LIM;
            speed_cmd_offset_r <= `EPS_RST_OFS;
            torque_cmd_offset_r <= `EPS_RST_OFS;
            monitor_ch1_offset_r <= `EPS_RST_OFS;
            monitor_ch2_offset_r <= `EPS_RST_OFS;
            out_mode_r <= `EPS_RST_MODE;
        end else begin
            if (wr_now & aligned & (idx == `EPS_IDX_TRQ_FS)) begin
                torque_cmd_full_scale_r <= (pwdata_in[15:0] > `EPS_TRQ_FS_MAX) ? `EPS_TRQ_FS_MAX : pwdata_in[15:0];
            end
            if (wr_now & aligned & (idx == `EPS_IDX_PULSE)) begin
                encoder_out_pulse_setting_r <= (pwdata_in[15:0] < `EPS_PULSE_MIN) ? `EPS_PULSE_MIN : pwdata_in[15:0];
            end
            if (wr_now & aligned & (idx == `EPS_IDX_TRQ_LIM)) begin
                internal_torque_limit_one_r <= (pwdata_in[15:0] > `EPS_TRQ_LIM_MAX) ? `EPS_TRQ_LIM_MAX : pwdata_in[15:0];
            end
            // calibration result lands in the same register software writes
            if (cal_state_r == CAL_TAKE) begin
                speed_cmd_offset_r <= clamp_ofs(-$signed({speed_command_input_in[15], speed_command_input_in}));
            end else if (wr_now & aligned & (idx == `EPS_IDX_SPD_OFS)) begin
                speed_cmd_offset_r <= clamp_ofs(wr_s);
            end
            if (wr_now & aligned & (idx == `EPS_IDX_TRQ_OFS)) begin
                torque_cmd_offset_r <= clamp_ofs(wr_s);
            end
            if (wr_now & aligned & (idx == `EPS_IDX_MON1_OFS)) begin
                monitor_ch1_offset_r <= clamp_ofs(wr_s);
            end
            if (wr_now & aligned & (idx == `EPS_IDX_MON2_OFS)) begin
                monitor_ch2_offset_r <= clamp_ofs(wr_s);
            end
            if (wr_now & aligned & (idx == `EPS_IDX_MODE)) begin
                out_mode_r <= pwdata_in[15:0];
            end
        end
    end

    // auto offset: let the input settle with 0 V applied, then take its negative
    always @(posedge core_clk_in) begin
        if (!nrst_in) begin
            cal_state_r <= CAL_IDLE;
            cal_cnt_r <= 16'h0000;
        end else begin
            case (cal_state_r)
                CAL_IDLE: begin
                    cal_cnt_r <= 16'h0000;
                    if (cal_go) begin
                        cal_state_r <= CAL_WAIT;
                    end
                end
                CAL_WAIT: begin
                    cal_cnt_r <= cal_cnt_r + 16'h0001;
                    if (cal_cnt_r == `EPS_CAL_WAIT - 16'h0001) begin
                        cal_state_r <= CAL_TAKE;
                    end
                end
                CAL_TAKE: begin
                    cal_state_r <= CAL_IDLE;
                end
                default: begin
                    cal_state_r <= CAL_IDLE;
                end
            endcase
        end
    end

    // encoder emulation: rate conversion by accumulator, one quadrature edge per cycle at most
    wire div_mode = (out_mode_r[`EPS_MODE_HI:`EPS_MODE_LO] == `EPS_MODE_DIV);
    wire [16:0] pos_diff = motor_pos_in - pos_prev_r;
    wire signed [17:0] delta = {pos_diff[16], pos_diff};
    // pulse mode adds the setting per count against the resolution, division mode the reverse
    wire signed [17:0] inc = div_mode ? 18'sh00001 : {2'b00, encoder_out_pulse_setting_r};
    wire signed [39:0] thr = div_mode ? {24'h000000, encoder_out_pulse_setting_r} : `EPS_ENC_RES;
    wire signed [35:0] step = delta * inc;
    wire signed [39:0] acc_sum = acc_r + {{4{step[35]}}, step};
    always @(posedge core_clk_in) begin
        if (!nrst_in) begin
            pos_prev_r <= 17'h00000;
            acc_r <= 40'sh0000000000;
            quad_r <= 2'h0;
            edge_cnt_r <= 16'h0000;
        end else begin
            pos_prev_r <= motor_pos_in;
            // each edge is one count of the setting, four edges make one a/b pulse
            if (acc_sum >= thr) begin
                acc_r <= acc_sum - thr;
                quad_r <= quad_r + 2'h1;
                edge_cnt_r <= edge_cnt_r + 16'h0001;
            end else if (acc_sum <= -thr) begin
                acc_r <= acc_sum + thr;
                quad_r <= quad_r - 2'h1;
                edge_cnt_r <= edge_cnt_r - 16'h0001;
            end else begin
                acc_r <= acc_sum;
            end
        end
    end

    // torque scaling and limiting in 0.1 % of max torque
    wire signed [16:0] tcmd_mv = add_ofs(torque_command_input_in, torque_cmd_offset_r);
    wire signed [16:0] alim_mv = add_ofs(torque_limit_input_in, torque_cmd_offset_r);
    wire signed [31:0] trq_prod = tcmd_mv * $signed({1'b0, torque_cmd_full_scale_r[10:0]});
    wire signed [31:0] trq_scaled = trq_prod / `EPS_TRQ_DIV;
    wire signed [16:0] int_lim = $signed({1'b0, internal_torque_limit_one_r}) * `EPS_LIM_SCALE;
    wire signed [16:0] alim_lim = (alim_mv < 17'sh00000) ? 17'sh00000 : (alim_mv >>> `EPS_ALIM_SHIFT);
    // the analog limit only narrows the internal one outside torque mode
    wire signed [16:0] lim = (!torque_mode && alim_lim < int_lim) ? alim_lim : int_lim;
    wire signed [31:0] lim_w = {{15{lim[16]}}, lim};
    // speed/limit channel by mode
    wire [15:0] spd_src = torque_mode ? speed_limit_input_in : speed_command_input_in;
    wire signed [16:0] spd_mv = add_ofs(spd_src, speed_cmd_offset_r);
    wire signed [16:0] mon1_mv = add_ofs(monitor_ch1_in, monitor_ch1_offset_r);
    wire signed [16:0] mon2_mv = add_ofs(monitor_ch2_in, monitor_ch2_offset_r);

    // registered outputs; a zero internal limit forces zero torque
    always @(posedge core_clk_in) begin
        if (!nrst_in) begin
            enc_a_out <= 1'b0;
            enc_b_out <= 1'b0;
            torque_ref_out <= 16'h0000;
            speed_ref_mv_out <= 16'h0000;
            monitor_ch1_mv_out <= 16'h0000;
            monitor_ch2_mv_out <= 16'h0000;
        end else begin
            enc_a_out <= quad_r[1];
            enc_b_out <= quad_r[1] ^ quad_r[0];
            if (!torque_mode) begin
                torque_ref_out <= lim[15:0];
            end else if (trq_scaled > lim_w) begin
                torque_ref_out <= lim[15:0];
            end else if (trq_scaled < -lim_w) begin
                torque_ref_out <= -lim[15:0];
            end else begin
                torque_ref_out <= trq_scaled[15:0];
            end
            speed_ref_mv_out <= spd_mv[15:0];
            monitor_ch1_mv_out <= mon1_mv[15:0];
            monitor_ch2_mv_out <= mon2_mv[15:0];
        end
    end

endmodule
`default_nettype wire

// ---- tb/eps_properties.sv ----
// port-level assertions for the encoder pulse and scaling block
`timescale 1ns/1ps
`default_nettype none
module eps_properties (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic nrst_in,
    // apb
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    // drive side
    input wire logic [1:0] control_mode_in,
    input wire logic enc_a_out,
    input wire logic enc_b_out,
    input wire logic [15:0] torque_ref_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);
    logic lim_zero_r;
    // shadow of "internal limit is zero", taken at the completing edge only
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            lim_zero_r <= 1'b0;
        end else if (psel_in && penable_in && pready_out && pwrite_in && paddr_in == 12'h070) begin
            lim_zero_r <= (pwdata_in[15:0] == 16'h0000);
        end
    end
    chk_ready_next: assert property (psel_in && !penable_in |=> pready_out)
        else $error("no ready after setup");
    chk_ready_pulse: assert property (pready_out |=> !pready_out)
        else $error("ready held too long");
    chk_err_ready: assert property (pslverr_out |-> pready_out)
        else $error("error without ready");
    chk_misalign_err: assert property (psel_in && !penable_in && paddr_in[1:0] != 2'h0 |=> pslverr_out)
        else $error("misaligned access accepted");
    chk_err_read_zero: assert property (pslverr_out && !pwrite_in |-> prdata_out == 32'h0)
        else $error("refused read returned data");
    chk_quad_step: assert property (!($changed(enc_a_out) && $changed(enc_b_out)))
        else $error("both phases moved at once");
    chk_trq_zero: assert property (lim_zero_r && $past(lim_zero_r, 2) |-> torque_ref_out == 16'h0000)
        else $error("torque with zero limit");
    chk_trq_range: assert property ($signed(torque_ref_out) <= 16'sh03E8 && $signed(torque_ref_out) >= -16'sh03E8)
        else $error("torque beyond full scale");
    chk_lim_nonneg: assert property (control_mode_in != 2'h2 && $past(control_mode_in) != 2'h2 |-> !torque_ref_out[15])
        else $error("negative limit outside torque mode");
    cover property (psel_in && penable_in && pready_out && pwrite_in);
    cover property (pslverr_out);
    cover property ($rose(enc_a_out));
endmodule
bind eps_top eps_properties chk_u (.core_clk_in, .nrst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .control_mode_in, .enc_a_out, .enc_b_out, .torque_ref_out);
`default_nettype wire

// ---- tb/eps_quad_rx.sv ----
// quadrature receiver model standing in for the positioning controller
`timescale 1ns/1ps
`default_nettype none
module eps_quad_rx (
    // clock and encoder lines
    input wire logic clk_in,
    input wire logic a_in,
    input wire logic b_in,
    // running counts, read as differences by the bench
    output var int edge_cnt_out,
    output var int a_pulse_out,
    output var int bad_out
);
    logic a_q = 1'b0;
    logic b_q = 1'b0;
    initial begin
        edge_cnt_out = 0;
        a_pulse_out = 0;
        bad_out = 0;
    end
    // one step per change; a double change is a lost step for a real counter
    // forward runs 00, 01, 11, 10 on (a, b): b leads a
    always @(posedge clk_in) begin
        a_q <= a_in;
        b_q <= b_in;
        if (a_in !== a_q && b_in !== b_q) begin
            bad_out <= bad_out + 1;
        end else if (a_in !== a_q) begin
            edge_cnt_out <= edge_cnt_out + ((a_in !== b_in) ? -1 : 1);
        end else if (b_in !== b_q) begin
            edge_cnt_out <= edge_cnt_out + ((a_in === b_in) ? -1 : 1);
        end
        if (a_in === 1'b1 && a_q === 1'b0) begin
            a_pulse_out <= a_pulse_out + 1;
        end
    end
endmodule
`default_nettype wire

// ---- tb/eps_top_tb.sv ----
// self-checking bench for the encoder pulse and scaling block
`timescale 1ns/1ps
`default_nettype none
module eps_top_tb;
    logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, ea, eb, rdy, err, re;
    logic [11:0] pa = 12'h000;
    logic [31:0] pwd = 32'h0, prd, rq;
    logic [16:0] pos = 17'h00000;
    logic [1:0] cm = 2'h0;
    logic [15:0] tcmd = 16'h0, scmd = 16'h0, vl = 16'h0, tl = 16'h0, m1 = 16'h0, m2 = 16'h0, tq, sp, o1, o2;
    int miscompares = 0, checks = 0, n, ec, ap, bd;
    initial forever #10 clk = ~clk;
    eps_top dut_u (.core_clk_in(clk), .nrst_in(nrst), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
        .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd), .pready_out(rdy), .pslverr_out(err),
        .motor_pos_in(pos), .control_mode_in(cm), .torque_command_input_in(tcmd), .speed_command_input_in(scmd),
        .speed_limit_input_in(vl), .torque_limit_input_in(tl), .monitor_ch1_in(m1), .monitor_ch2_in(m2),
        .enc_a_out(ea), .enc_b_out(eb), .torque_ref_out(tq), .speed_ref_mv_out(sp),
        .monitor_ch1_mv_out(o1), .monitor_ch2_mv_out(o2));
    eps_quad_rx rx_u (.clk_in(clk), .a_in(ea), .b_in(eb), .edge_cnt_out(ec), .a_pulse_out(ap), .bad_out(bd));
    task automatic close_out;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] g, input logic [31:0] x);
        checks++;
        if (g !== x) begin
            miscompares++;
            $display("Error t=%0t got %h exp %h", $time, g, x);
        end
    endtask
    // one apb transfer; request held until ready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1; pwr <= w; pa <= a; pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        k = 0;
        do begin @(posedge clk); k++; end while (rdy !== 1'b1 && k < 20);
        if (k >= 20) begin miscompares++; close_out; end
        rq = prd;
        re = err;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] x); apb(1'b0, a, 32'h0); cmp(rq, x); endtask
    task automatic rde(input logic [11:0] a); apb(1'b0, a, 32'h0); cmp({re, rq[30:0]}, 32'h80000000); endtask
    // outputs are registered: three edges cover input sampling and output launch
    task automatic settle; repeat (3) @(posedge clk); endtask
    // step the motor; small steps keep the edge rate well under the output maximum
    task automatic move(input int steps, input int d, input int xe, input int xa);
        int e, a, b;
        e = ec; a = ap; b = bd;
        repeat (steps) begin @(posedge clk); pos <= pos + d[16:0]; end
        repeat (8) @(posedge clk);
        cmp(ec - e, xe); cmp(ap - a, xa); cmp(bd - b, 0);
    endtask
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        rdc(12'h068, 32'h64);
        rdc(12'h06C, 32'hFA0);
        rdc(12'h070, 32'h64);
        rdc(12'h078, 32'h0);
        rdc(12'h07C, 32'h0);
        rdc(12'h080, 32'h0);
        rde(12'h004);
        rde(12'h06A);
        // out-of-range writes clamp
        wr(12'h068, 32'h7D0); rdc(12'h068, 32'h3E8);
        wr(12'h070, 32'h96); rdc(12'h070, 32'h64);
        wr(12'h078, 32'h4B0); rdc(12'h078, 32'h3E7);
        wr(12'h07C, 32'hFFFFFA24); rdc(12'h07C, 32'hFFFFFC19);
        wr(12'h06C, 32'h0); rdc(12'h06C, 32'h1);
        wr(12'h06C, 32'hFFFF); rdc(12'h06C, 32'hFFFF);
        // offsets on monitor and speed paths
        wr(12'h07C, 32'hFFFFFFCE); wr(12'h080, 32'h3E7); wr(12'h074, 32'h64); wr(12'h078, 32'h0);
        m1 <= 16'h3E8; cm <= 2'h1; scmd <= 16'h1F4; vl <= 16'h0C8; tl <= 16'h0FA0;
        settle(); cmp(o1, 32'h3B6);
        settle(); cmp(o2, 32'h3E7);
        settle(); cmp(sp, 32'h258);
        settle(); cmp(tq, 32'h1F4);
        cm <= 2'h2;
        settle(); cmp(sp, 32'h12C);
        // torque scaling at full scale, then with an offset, then zero limit
        wr(12'h068, 32'h32); tcmd <= 16'h1F40;
        settle(); cmp(tq, 32'h1F4);
        tcmd <= 16'hE0C0;
        settle(); cmp(tq, 32'hFE0C);
        wr(12'h078, 32'h50);
        settle(); cmp(tq, 32'hFE11);
        wr(12'h070, 32'h0);
        settle(); cmp(tq, 32'h0);
        // automatic offset writes the negated command
        scmd <= 16'h0025; wr(12'h100, 32'h1);
        n = 0;
        do begin apb(1'b0, 12'h100, 32'h0); n++; end while (rq[0] === 1'b1 && n < 600);
        if (n >= 600) begin miscompares++; close_out; end
        rdc(12'h074, 32'hFFFFFFDB);
        // encoder emulation, pulse mode both ways then division mode
        wr(12'h06C, 32'h190);
        move(16384, 8, 400, 100);
        move(16384, -8, -400, 100);
        wr(12'h0D8, 32'h1000); wr(12'h06C, 32'h400);
        move(16384, 8, 128, 32);
        close_out;
    end
endmodule
`default_nettype wire
